// *** common/csw_map.vh ***
// csw_map.vh: offsets, field positions, reset values and timing counts
// of the clock switch hold and status block. definitions only.
`ifndef CSW_MAP_VH
`define CSW_MAP_VH

// register addresses (word index on the plain register port)
`define CSW_ADDR_HOLD_STATUS 4'h0
`define CSW_ADDR_IRQ_STATUS 4'h1
`define CSW_ADDR_IRQ_MASK 4'h2

// hold and status register fields
`define CSW_BIT_HOLD 7
`define CSW_BIT_SOSC_PWR 6
`define CSW_BIT_OSC_RDY 4
`define CSW_BIT_NEW_RDY 3
`define CSW_HOLD_STATUS_RST 8'h00

// interrupt status / mask fields
`define CSW_IRQ_HELD 0
`define CSW_IRQ_DONE 1
`define CSW_IRQ_MASK_RST 8'h00

// instruction cycle = 4 system clocks
`define CSW_ICYC_CLKS 4
`define CSW_ICYC_CNT_W 2

`endif

// *** rtl/csw_clock_switch_ctrl.v ***
// csw_clock_switch_ctrl.v: clock switch hold and status control.
// assumes the oscillator selection registers and the oscillators sit outside;
// all inputs except the asynchronous active-low reset rstn_in are synchronous to core_clk_in.
//
// Behaviour
// R1: hold bit 1 holds switch and interrupts on ready; 0 lets it proceed.
// R2: power select bit 1 runs secondary oscillator high power, 0 low power.
// R3: oscillator-ready flag is 1 when current equals requested selection.
// R4: new-ready flag set when switching and new oscillator ready, lag one cycle.
// R5: hold 0: switch next instruction cycle after flag set, flag clears.
// R6: hardware clears the hold bit once a held switch is carried out.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "csw_map.vh"

module csw_clock_switch_ctrl (
    input wire core_clk_in,
    input wire rstn_in,
    input wire [3:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    input wire [2:0] requested_osc_select_in,
    input wire [2:0] current_osc_select_in,
    input wire new_osc_ready_in,
    output reg switch_clock_out,
    output reg secondary_osc_power_select_out,
    output wire irq_out
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_HELD = 3'b100;
    localparam [7:0] HS_RST = `CSW_HOLD_STATUS_RST;
    localparam [7:0] IRQ_MASK_RST = `CSW_IRQ_MASK_RST;
    localparam [7:0] IRQ_MASK_BITS = 8'h03;

    wire icyc_en;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg hold_q;
    reg new_rdy_q;
    reg [7:0] irq_stat_q;
    reg [7:0] irq_mask_q;
    reg held_evt;
    reg done_evt;
    reg do_switch;
    wire in_progress;
    wire osc_rdy;
    wire [7:0] status_byte;
    wire wr_hold_sel;
    wire wr_mask_sel;
    wire rd_stat_sel;
    reg hold_d;
    reg pwr_d;
    reg [7:0] irq_mask_d;
    reg [7:0] irq_stat_d;
    reg [7:0] rdata_d;

    csw_icyc_div u_div (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .icyc_en_out(icyc_en)
    );

    function wire_sel;
        input [3:0] a;
        input [3:0] b;
        begin
            wire_sel = (a == b);
        end
    endfunction

    assign in_progress = (requested_osc_select_in != current_osc_select_in);
    assign osc_rdy = !in_progress; // [R3]
    // new-ready drops as soon as the selections match, not one clock later
    assign status_byte = {hold_q, secondary_osc_power_select_out, 1'b0, osc_rdy,
                          new_rdy_q && in_progress, 3'b000}; // [R4]

    // switch sequencing on instruction-cycle boundaries
    always @* begin
        state_d = state_q;
        held_evt = 1'b0;
        done_evt = 1'b0;
        do_switch = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (in_progress && new_osc_ready_in && icyc_en) begin
                    if (hold_q) begin
                        state_d = ST_HELD; // [R1]
                        held_evt = 1'b1;
                    end else begin
                        state_d = ST_WAIT; // [R4]
                    end
                end
            end
            ST_WAIT: begin
                if (!in_progress || !new_osc_ready_in) begin
                    state_d = ST_IDLE;
                end else if (hold_q) begin
                    state_d = ST_HELD;
                    held_evt = 1'b1;
                end else if (icyc_en) begin
                    do_switch = 1'b1; // [R5]
                    done_evt = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_HELD: begin
                if (!in_progress || !new_osc_ready_in) begin
                    state_d = ST_IDLE;
                end else if (!hold_q && icyc_en) begin
                    do_switch = 1'b1; // [R1]
                    done_evt = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= ST_IDLE;
            new_rdy_q <= 1'b0;
            switch_clock_out <= 1'b0;
        end else begin
            state_q <= state_d;
            switch_clock_out <= do_switch;
            new_rdy_q <= (state_d == ST_WAIT) || (state_d == ST_HELD); // [R4] [R5]
        end
    end

    // register port decode
    assign wr_hold_sel = reg_wr_in && wire_sel(reg_addr_in, `CSW_ADDR_HOLD_STATUS);
    assign wr_mask_sel = reg_wr_in && wire_sel(reg_addr_in, `CSW_ADDR_IRQ_MASK);
    assign rd_stat_sel = reg_rd_in && wire_sel(reg_addr_in, `CSW_ADDR_IRQ_STATUS);

    // software-visible control bits; the hardware clear after a held switch
    // beats a software write in the same cycle
    always @* begin
        hold_d = hold_q;
        pwr_d = secondary_osc_power_select_out;
        irq_mask_d = irq_mask_q;
        if (wr_hold_sel) begin
            hold_d = reg_wdata_in[`CSW_BIT_HOLD];
            pwr_d = reg_wdata_in[`CSW_BIT_SOSC_PWR]; // [R2]
        end
        if (wr_mask_sel) begin
            irq_mask_d = reg_wdata_in & IRQ_MASK_BITS;
        end
        if (do_switch && (state_q == ST_HELD)) begin
            hold_d = 1'b0; // [R6]
        end
    end

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hold_q <= HS_RST[`CSW_BIT_HOLD];
            secondary_osc_power_select_out <= HS_RST[`CSW_BIT_SOSC_PWR];
            irq_mask_q <= IRQ_MASK_RST;
        end else begin
            hold_q <= hold_d;
            secondary_osc_power_select_out <= pwr_d; // [R2]
            irq_mask_q <= irq_mask_d;
        end
    end

    // sticky event bits: read clears, a new event in the same cycle wins
    always @* begin
        irq_stat_d = irq_stat_q;
        if (rd_stat_sel) begin
            irq_stat_d = 8'h00;
        end
        if (held_evt) begin
            irq_stat_d[`CSW_IRQ_HELD] = 1'b1; // [R1]
        end
        if (done_evt) begin
            irq_stat_d[`CSW_IRQ_DONE] = 1'b1; // [R5]
        end
    end

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_stat_q <= 8'h00;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // interrupt level: any unmasked sticky event
    assign irq_out = |(irq_stat_q & irq_mask_q);

    // read data stand only in the cycle after the strobe, zero otherwise
    always @* begin
        rdata_d = 8'h00;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `CSW_ADDR_HOLD_STATUS: begin
                    rdata_d = status_byte; // [R3] [R4]
                end
                `CSW_ADDR_IRQ_STATUS: begin
                    rdata_d = irq_stat_q;
                end
                `CSW_ADDR_IRQ_MASK: begin
                    rdata_d = irq_mask_q;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= rdata_d;
        end
    end
endmodule

// *** rtl/csw_icyc_div.v ***
// csw_icyc_div.v: divider giving a one-cycle instruction-cycle enable.
// assumes one clock, asynchronous active-low reset.
`timescale 1ns/10ps
`include "csw_map.vh"

module csw_icyc_div (
    input wire core_clk_in,
    input wire rstn_in,
    output wire icyc_en_out
);
    reg [`CSW_ICYC_CNT_W-1:0] cnt_q;

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= {`CSW_ICYC_CNT_W{1'b0}};
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign icyc_en_out = (cnt_q == (`CSW_ICYC_CLKS - 1));
endmodule

// *** tb/csw_clock_switch_ctrl_tb_top.sv ***
// testbench for the clock switch hold and status control.
// assumes the design top and its map header; drives all ports itself.
`timescale 1ns/10ps
module csw_clock_switch_ctrl_tb_top;
    logic core_clk_in = 0, rstn_in = 0, wr = 0, rd = 0, rdy = 0;
    logic [3:0] addr = 0;
    logic [7:0] wd = 0, q;
    logic [2:0] req = 0, cur = 0;
    wire [7:0] rdat;
    wire sw, pwr, irq;
    int miscompares = 0, n_tests = 0, pulses = 0, cyc = 0;
    always #50 core_clk_in = ~core_clk_in;
    csw_clock_switch_ctrl csw_clock_switch_ctrl_i (.core_clk_in(core_clk_in),
        .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdat), .requested_osc_select_in(req),
        .current_osc_select_in(cur), .new_osc_ready_in(rdy), .switch_clock_out(sw),
        .secondary_osc_power_select_out(pwr), .irq_out(irq));
    task finish_test;
        if (miscompares == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (sw === 1'b1) pulses <= pulses + 1;
        if (cyc == 3000) begin
            miscompares++;
            finish_test;
        end
    end
    task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr <= a;
        wd <= d;
        wr <= 1;
        @(posedge core_clk_in);
        wr <= 0;
    endtask
    task rd_reg(input logic [3:0] a);
        @(posedge core_clk_in);
        addr <= a;
        rd <= 1;
        @(posedge core_clk_in);
        rd <= 0;
        @(posedge core_clk_in);
        q = rdat;
    endtask
    // waits for one more switch pulse, at most 20 cycles
    task wait_sw(input int n0);
        repeat (20) if (pulses == n0) @(posedge core_clk_in);
        chk("switch", 8'(pulses), 8'(n0 + 1));
    endtask
    initial begin
        repeat (10) @(posedge core_clk_in);
        rstn_in <= 1;
        rd_reg(0); chk("stat", q, 8'h10);
        rd_reg(2); chk("mask", q, 8'h00);
        wr_reg(0, 8'h40);
        rd_reg(0); chk("stat", q, 8'h50);
        chk("pwr", pwr, 1);
        wr_reg(0, 8'h00);
        @(posedge core_clk_in);
        chk("pwr", pwr, 0);
        wr_reg(2, 8'h03);
        req <= 1;
        rdy <= 1;
        rd_reg(0); chk("busy", q[4], 0);
        wait_sw(0);
        cur <= 1;
        rdy <= 0;
        chk("irq", irq, 1);
        rd_reg(0); chk("stat", q, 8'h10);
        rd_reg(1); chk("isr", q, 8'h02);
        chk("irq", irq, 0);
        wr_reg(0, 8'h80);
        wr_reg(2, 8'h01);
        req <= 2;
        rdy <= 1;
        repeat (12) @(posedge core_clk_in);
        chk("held", 8'(pulses), 8'd1);
        chk("irq", irq, 1);
        rd_reg(0); chk("stat", q, 8'h88);
        rd_reg(1); chk("isr", q, 8'h01);
        wr_reg(0, 8'h00);
        wait_sw(1);
        cur <= 2;
        rdy <= 0;
        chk("irq", irq, 0);
        rd_reg(0); chk("stat", q, 8'h10);
        rd_reg(1); chk("isr", q, 8'h02);
        rd_reg(5); chk("unmapped", q, 8'h00);
        finish_test;
    end
endmodule

// *** tb/csw_ctrl_asserts.sv ***
// port checker for the clock switch hold and status control.
// assumes it is bound to the control's top module.
`timescale 1ns/10ps
module csw_ctrl_asserts (
    input wire core_clk_in,
    input wire rstn_in,
    input wire [3:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire [2:0] requested_osc_select_in,
    input wire [2:0] current_osc_select_in,
    input wire new_osc_ready_in,
    input wire switch_clock_out,
    input wire secondary_osc_power_select_out,
    input wire irq_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    a_pwr_follows_wr: assert property (reg_wr_in && reg_addr_in == 4'h0
        |=> secondary_osc_power_select_out == $past(reg_wdata_in[6])) else $error("power");
    a_switch_needs_rdy: assert property (switch_clock_out
        |-> $past(new_osc_ready_in)) else $error("switch without ready");
    a_switch_on_diff: assert property (switch_clock_out
        |-> $past(requested_osc_select_in != current_osc_select_in)) else $error("no switch due");
    a_switch_one_pulse: assert property (switch_clock_out |=> !switch_clock_out)
        else $error("switch pulse long");
    a_osc_rdy_read: assert property (reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out[4]
        == $past(requested_osc_select_in == current_osc_select_in)) else $error("osc ready");
    a_flags_exclusive: assert property (reg_rd_in && reg_addr_in == 4'h0
        |=> !(reg_rdata_out[3] && reg_rdata_out[4])) else $error("both flags");
    a_switch_drops_new: assert property (switch_clock_out && reg_rd_in
        && reg_addr_in == 4'h0 |=> !reg_rdata_out[3]) else $error("new ready after switch");
    a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data stands");
endmodule
bind csw_clock_switch_ctrl csw_ctrl_asserts csw_ctrl_asserts_i (.*);
